/* File: logic/calibration_vector_and_trim_regs.sv */
`timescale 1ns/10ps
`include "cal_trim_regs.svh"
module calibration_vector_and_trim_regs
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        calibration_halted_flag,
   input  wire logic [7:0]  fuse_channel_a_gain,
   input  wire logic [7:0]  fuse_channel_b_gain,
   input  wire logic [3:0]  fuse_reference_voltage,
   input  wire logic [7:0]  fuse_channel_a_termination,
   input  wire logic [7:0]  fuse_channel_b_termination,
   input  wire logic [9:0]  engine_index,
   output      logic [7:0]  engine_byte,
   output      logic        cal_vector_valid,
   output      logic [7:0]  channel_a_gain_adjust,
   output      logic [7:0]  channel_b_gain_adjust,
   output      logic [3:0]  reference_voltage_adjust,
   output      logic [7:0]  channel_a_termination_adjust,
   output      logic [7:0]  channel_b_termination_adjust
);

   function automatic logic is_reg(input logic [11:0] addr,
                                   input logic [9:0]  idx);
      is_reg = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
   endfunction : is_reg

   logic [1:0]               halted_sync_q;
   logic                     halted;
   logic [35:0]              fuse_s1_q;
   logic [35:0]              fuse_s2_q;
   logic [1:0]               fuse_cnt_q;
   logic [7:0]               access_enable_q;
   logic [9:0]               ptr_q;
   logic [9:0]               drain_idx_q;
   cal_trim_pkg::seq_state_t seq_q;
   logic                     error_q;
   logic                     valid_q;
   cal_trim_pkg::byte_t      vec_mem_q [0:672];

   logic                     hit_en;
   logic                     hit_port;
   logic                     hit_status;
   logic                     hit_a_gain;
   logic                     hit_b_gain;
   logic                     hit_ref;
   logic                     hit_a_term;
   logic                     hit_b_term;
   logic                     mapped;
   logic                     can_done;
   logic                     commit;
   logic                     port_wr;
   logic                     port_rd;
   logic                     corrupt;
   logic                     good_wr;
   logic                     good_rd;
   logic                     mismatch;
   logic                     enable_rise;
   logic                     abort;
   logic                     fifo_in_ready;
   logic                     fifo_out_valid;
   logic [7:0]               fifo_out_data;
   logic                     drain;
   logic [7:0]               rdata;

   // halted flag and fuse straps come from outside the clock domain
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         halted_sync_q <= 2'b00;
      end
      else
      begin
         halted_sync_q <= {halted_sync_q[0], calibration_halted_flag};
      end
   end

   assign halted = halted_sync_q[1];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fuse_s1_q <= 36'h0_0000_0000;
         fuse_s2_q <= 36'h0_0000_0000;
      end
      else
      begin
         fuse_s1_q <= {fuse_channel_a_gain, fuse_channel_b_gain,
                       fuse_reference_voltage,
                       fuse_channel_a_termination,
                       fuse_channel_b_termination};
         fuse_s2_q <= fuse_s1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fuse_cnt_q <= 2'd0;
      end
      else if (fuse_cnt_q != `CVT_FUSE_DONE)
      begin
         fuse_cnt_q <= fuse_cnt_q + 2'd1;
      end
   end

   // address decode
   assign hit_en     = is_reg(paddr, `CVT_IDX_ACCESS_EN);
   assign hit_port   = is_reg(paddr, `CVT_IDX_VEC_PORT);
   assign hit_status = is_reg(paddr, `CVT_IDX_STATUS);
   assign hit_a_gain = is_reg(paddr, `CVT_IDX_A_GAIN);
   assign hit_b_gain = is_reg(paddr, `CVT_IDX_B_GAIN);
   assign hit_ref    = is_reg(paddr, `CVT_IDX_REF_ADJ);
   assign hit_a_term = is_reg(paddr, `CVT_IDX_A_TERM);
   assign hit_b_term = is_reg(paddr, `CVT_IDX_B_TERM);
   assign mapped     = hit_en | hit_port | hit_status | hit_a_gain
                     | hit_b_gain | hit_ref | hit_a_term | hit_b_term;

   // wait states: fuse capture, full buffer, undrained bytes
   always_comb
   begin
      if (fuse_cnt_q != `CVT_FUSE_DONE)
      begin
         can_done = 1'b0;
      end
      else if (hit_port && access_enable_q[`CVT_EN_BIT] && pwrite)
      begin
         can_done = fifo_in_ready;
      end
      else if (hit_port && access_enable_q[`CVT_EN_BIT])
      begin
         can_done = !fifo_out_valid;
      end
      else if (hit_en && pwrite)
      begin
         can_done = !fifo_out_valid;
      end
      else
      begin
         can_done = 1'b1;
      end
   end

   assign commit  = psel & penable & !pready & can_done;
   assign port_wr = commit & pwrite & hit_port
                  & access_enable_q[`CVT_EN_BIT];
   assign port_rd = commit & !pwrite & hit_port
                  & access_enable_q[`CVT_EN_BIT];
   assign corrupt = (port_wr | port_rd) & !halted;
   assign good_wr = port_wr & halted
                  & ((seq_q == cal_trim_pkg::seq_idle)
                  | (seq_q == cal_trim_pkg::seq_write));
   assign good_rd = port_rd & halted
                  & ((seq_q == cal_trim_pkg::seq_idle)
                  | (seq_q == cal_trim_pkg::seq_read));
   assign mismatch = (port_wr | port_rd) & halted & !good_wr & !good_rd
                   & (seq_q != cal_trim_pkg::seq_done);
   assign enable_rise = commit & pwrite & hit_en
                      & pwdata[`CVT_EN_BIT]
                      & !access_enable_q[`CVT_EN_BIT];
   assign abort = commit & pwrite & hit_en & !pwdata[`CVT_EN_BIT]
                & access_enable_q[`CVT_EN_BIT]
                & ((seq_q == cal_trim_pkg::seq_read)
                | (seq_q == cal_trim_pkg::seq_write));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         access_enable_q <= `CVT_RST_BYTE;
      end
      else if (commit && pwrite && hit_en)
      begin
         access_enable_q <= pwdata[7:0];
      end
   end

   // byte pointer and sequence direction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ptr_q <= 10'd0;
         seq_q <= cal_trim_pkg::seq_idle;
      end
      else if (enable_rise)
      begin
         ptr_q <= 10'd0;
         seq_q <= cal_trim_pkg::seq_idle;
      end
      else if (abort)
      begin
         seq_q <= cal_trim_pkg::seq_idle;
      end
      else if (good_rd || good_wr)
      begin
         ptr_q <= ptr_q + 10'd1;
         if (ptr_q == `CVT_VEC_LAST)
         begin
            seq_q <= cal_trim_pkg::seq_done;
         end
         else if (good_rd)
         begin
            seq_q <= cal_trim_pkg::seq_read;
         end
         else
         begin
            seq_q <= cal_trim_pkg::seq_write;
         end
      end
   end

   // written bytes queue here until the engine is halted
   cal_byte_fifo
   #(
      .WIDTH (`CVT_FIFO_WIDTH),
      .DEPTH (`CVT_FIFO_DEPTH)
   )
   u_fifo
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (good_wr),
      .in_data   (pwdata[7:0]),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (halted)
   );

   assign drain = fifo_out_valid & halted;

   always_ff @(posedge pclk)
   begin
      if (drain)
      begin
         vec_mem_q[drain_idx_q] <= fifo_out_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drain_idx_q <= 10'd0;
      end
      else if (enable_rise)
      begin
         drain_idx_q <= 10'd0;
      end
      else if (drain)
      begin
         drain_idx_q <= drain_idx_q + 10'd1;
      end
   end

   // sticky error; a new event beats the clear on enable rise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         error_q <= 1'b0;
      end
      else if (corrupt || abort || mismatch)
      begin
         error_q <= 1'b1;
      end
      else if (enable_rise)
      begin
         error_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         valid_q <= 1'b0;
      end
      else if (corrupt || abort || mismatch)
      begin
         valid_q <= 1'b0;
      end
      else if (good_wr && ptr_q == 10'd0)
      begin
         valid_q <= 1'b0;
      end
      else if (drain && drain_idx_q == `CVT_VEC_LAST && !error_q)
      begin
         valid_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cal_vector_valid <= 1'b0;
         engine_byte      <= `CVT_RST_BYTE;
      end
      else
      begin
         cal_vector_valid <= valid_q;
         if (engine_index < `CVT_VEC_LEN)
         begin
            engine_byte <= vec_mem_q[engine_index];
         end
      end
   end

   // trims take the fuse values once the straps are synchronised
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         channel_a_gain_adjust        <= `CVT_RST_BYTE;
         channel_b_gain_adjust        <= `CVT_RST_BYTE;
         reference_voltage_adjust     <= `CVT_RST_REF;
         channel_a_termination_adjust <= `CVT_RST_BYTE;
         channel_b_termination_adjust <= `CVT_RST_BYTE;
      end
      else if (fuse_cnt_q == `CVT_FUSE_LOAD)
      begin
         channel_a_gain_adjust        <= fuse_s2_q[35:28];
         channel_b_gain_adjust        <= fuse_s2_q[27:20];
         reference_voltage_adjust     <= fuse_s2_q[19:16];
         channel_a_termination_adjust <= fuse_s2_q[15:8];
         channel_b_termination_adjust <= fuse_s2_q[7:0];
      end
      else if (commit && pwrite)
      begin
         if (hit_a_gain)
         begin
            channel_a_gain_adjust <= pwdata[7:0];
         end
         if (hit_b_gain)
         begin
            channel_b_gain_adjust <= pwdata[7:0];
         end
         if (hit_ref)
         begin
            reference_voltage_adjust <= pwdata[3:0];
         end
         if (hit_a_term)
         begin
            channel_a_termination_adjust <= pwdata[7:0];
         end
         if (hit_b_term)
         begin
            channel_b_termination_adjust <= pwdata[7:0];
         end
      end
   end

   // read data mux
   always_comb
   begin
      rdata = `CVT_RST_BYTE;
      if (hit_en)
      begin
         rdata = access_enable_q;
      end
      else if (hit_port && good_rd)
      begin
         rdata = vec_mem_q[ptr_q];
      end
      else if (hit_status)
      begin
         rdata[`CVT_ST_HALTED] = halted;
         rdata[`CVT_ST_VALID]  = valid_q;
         rdata[`CVT_ST_ERROR]  = error_q;
         rdata[`CVT_ST_DONE]   = (seq_q == cal_trim_pkg::seq_done);
      end
      else if (hit_a_gain)
      begin
         rdata = channel_a_gain_adjust;
      end
      else if (hit_b_gain)
      begin
         rdata = channel_b_gain_adjust;
      end
      else if (hit_ref)
      begin
         rdata = {4'h0, reference_voltage_adjust};
      end
      else if (hit_a_term)
      begin
         rdata = channel_a_termination_adjust;
      end
      else if (hit_b_term)
      begin
         rdata = channel_b_termination_adjust;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `CVT_RST_WORD;
      end
      else
      begin
         pready  <= commit;
         pslverr <= commit & !mapped;
         if (commit && !pwrite)
         begin
            prdata <= {24'h00_0000, rdata};
         end
         else
         begin
            prdata <= `CVT_RST_WORD;
         end
      end
   end

endmodule : calibration_vector_and_trim_regs

/* File: logic/cal_trim_regs.svh */
`ifndef CAL_TRIM_REGS_SVH
`define CAL_TRIM_REGS_SVH

// register indices; byte address is four times the index
`define CVT_IDX_ACCESS_EN 10'h070
`define CVT_IDX_VEC_PORT  10'h071
`define CVT_IDX_STATUS    10'h072
`define CVT_IDX_A_GAIN    10'h07a
`define CVT_IDX_B_GAIN    10'h07b
`define CVT_IDX_REF_ADJ   10'h07c
`define CVT_IDX_A_TERM    10'h07e
`define CVT_IDX_B_TERM    10'h07f

// reset values
`define CVT_RST_BYTE      8'h00
`define CVT_RST_REF       4'h0
`define CVT_RST_WORD      32'h0000_0000

// field positions
`define CVT_EN_BIT        0
`define CVT_ST_HALTED     0
`define CVT_ST_VALID      1
`define CVT_ST_ERROR      2
`define CVT_ST_DONE       3

// vector length and buffering
`define CVT_VEC_LEN       10'd673
`define CVT_VEC_LAST      10'd672
`define CVT_FIFO_DEPTH    16
`define CVT_FIFO_WIDTH    8

// fuse capture timing, counted in pclk cycles after reset release
`define CVT_FUSE_LOAD     2'd2
`define CVT_FUSE_DONE     2'd3

`endif

/* File: logic/cal_trim_pkg.sv */
package cal_trim_pkg;

   typedef enum logic [1:0]
   {
      seq_idle  = 2'b00,
      seq_read  = 2'b01,
      seq_write = 2'b10,
      seq_done  = 2'b11
   } seq_state_t;

   typedef logic [7:0] byte_t;

endpackage : cal_trim_pkg

/* File: logic/cal_byte_fifo.sv */
`timescale 1ns/10ps
module cal_byte_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             in_ready,
   output      logic             out_valid,
   output      logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != FULL);
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge pclk)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop)
         begin
            count_q <= count_q + 1'b1;
         end
         else if (pop && !push)
         begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule : cal_byte_fifo

/* File: bench/cal_trim_chk.sv */
`timescale 1ns/10ps
`include "cal_trim_regs.svh"
module cal_trim_chk
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        calibration_halted_flag,
   input logic [9:0]  engine_index,
   input logic [7:0]  engine_byte,
   input logic        cal_vector_valid,
   input logic [7:0]  channel_a_gain_adjust,
   input logic [7:0]  channel_b_gain_adjust,
   input logic [3:0]  reference_voltage_adjust,
   input logic [7:0]  channel_a_termination_adjust,
   input logic [7:0]  channel_b_termination_adjust
);
   localparam logic [11:0] ad_ag = {`CVT_IDX_A_GAIN, 2'b00};
   localparam logic [11:0] ad_bg = {`CVT_IDX_B_GAIN, 2'b00};
   localparam logic [11:0] ad_rf = {`CVT_IDX_REF_ADJ, 2'b00};
   localparam logic [11:0] ad_at = {`CVT_IDX_A_TERM, 2'b00};
   localparam logic [11:0] ad_bt = {`CVT_IDX_B_TERM, 2'b00};
   localparam logic [11:0] ad_vp = {`CVT_IDX_VEC_PORT, 2'b00};
   wire logic wr_done = psel && penable && pready && pwrite;
   wire logic rd_done = psel && penable && pready && !pwrite;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_gain_wr_a:
      assert property (wr_done && paddr == ad_ag
         |-> channel_a_gain_adjust == pwdata[7:0])
      else $error("channel a gain write not applied");
   a_gain_rd_a:
      assert property (rd_done && paddr == ad_ag
         |-> prdata == {24'h0, channel_a_gain_adjust})
      else $error("channel a gain readback differs");
   b_gain_wr_a:
      assert property (wr_done && paddr == ad_bg
         |-> channel_b_gain_adjust == pwdata[7:0])
      else $error("channel b gain write not applied");
   ref_trim_wr_a:
      assert property (wr_done && paddr == ad_rf
         |-> reference_voltage_adjust == pwdata[3:0])
      else $error("reference trim write not applied");
   ref_upper_zero_a:
      assert property (rd_done && paddr == ad_rf |-> prdata[31:4] == 28'h0)
      else $error("reference trim upper bits not zero");
   a_term_wr_a:
      assert property (wr_done && paddr == ad_at
         |-> channel_a_termination_adjust == pwdata[7:0])
      else $error("channel a termination write not applied");
   b_term_wr_a:
      assert property (wr_done && paddr == ad_bt
         |-> channel_b_termination_adjust == pwdata[7:0])
      else $error("channel b termination write not applied");
   running_read_a:
      assert property ((!calibration_halted_flag)[*4] ##0
         (rd_done && paddr == ad_vp) |-> prdata == 32'h0)
      else $error("vector read returned data while running");
   engine_hold_a:
      assert property (engine_index >= `CVT_VEC_LEN |=> $stable(engine_byte))
      else $error("engine byte moved for out of range index");

   cover property (wr_done && paddr == ad_vp);
   cover property (rd_done && paddr == ad_vp);
   cover property ($rose(cal_vector_valid));
endmodule : cal_trim_chk

/* File: bench/tb.sv */
`timescale 1ns/10ps
`include "cal_trim_regs.svh"
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        calibration_halted_flag = 1'b1;
   logic [35:0] fuse = 36'h1_2349_5678;
   logic [9:0]  engine_index = 10'h000;
   logic [7:0]  engine_byte;
   logic        cal_vector_valid;
   logic [7:0]  channel_a_gain_adjust;
   logic [7:0]  channel_b_gain_adjust;
   logic [3:0]  reference_voltage_adjust;
   logic [7:0]  channel_a_termination_adjust;
   logic [7:0]  channel_b_termination_adjust;
   int          failures = 0;
   int          check_count = 0;
   logic [31:0] rd;
   logic        er;
   typedef struct {logic [9:0] idx; logic [31:0] wd, ex; logic err;} row_t;
   row_t rows [7] = '{
      '{`CVT_IDX_A_GAIN, 32'h0000_00c3, 32'h0000_00c3, 1'b0},
      '{`CVT_IDX_B_GAIN, 32'h0000_003c, 32'h0000_003c, 1'b0},
      '{`CVT_IDX_REF_ADJ, 32'h0000_00ff, 32'h0000_000f, 1'b0},
      '{`CVT_IDX_A_TERM, 32'h0000_00a5, 32'h0000_00a5, 1'b0},
      '{`CVT_IDX_B_TERM, 32'h0000_005a, 32'h0000_005a, 1'b0},
      '{`CVT_IDX_ACCESS_EN, 32'h0000_00fe, 32'h0000_00fe, 1'b0},
      '{10'h07d, 32'h0000_0011, 32'h0000_0000, 1'b1}};

   always #12.5 pclk = ~pclk;

   calibration_vector_and_trim_regs uut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .calibration_halted_flag(calibration_halted_flag),
      .fuse_channel_a_gain(fuse[35:28]), .fuse_channel_b_gain(fuse[27:20]),
      .fuse_reference_voltage(fuse[19:16]),
      .fuse_channel_a_termination(fuse[15:8]),
      .fuse_channel_b_termination(fuse[7:0]), .engine_index(engine_index),
      .engine_byte(engine_byte), .cal_vector_valid(cal_vector_valid),
      .channel_a_gain_adjust(channel_a_gain_adjust),
      .channel_b_gain_adjust(channel_b_gain_adjust),
      .reference_voltage_adjust(reference_voltage_adjust),
      .channel_a_termination_adjust(channel_a_termination_adjust),
      .channel_b_termination_adjust(channel_b_termination_adjust)
   );

   function automatic logic [31:0] pat(input int i);
      return {24'h0, 8'(i * 37 + 11)};
   endfunction : pat

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic end_sim();
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // one apb transfer, waits for pready at a rising edge
   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic set_en(input logic [31:0] v);
      apb(1'b1, `CVT_IDX_ACCESS_EN, v);
   endtask : set_en

   task automatic status_is(input logic [31:0] mask, input logic [31:0] ex);
      apb(1'b0, `CVT_IDX_STATUS, 32'h0);
      check(rd & mask, ex);
   endtask : status_is

   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      end_sim();
   end

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      check({24'h0, channel_a_gain_adjust}, 32'h12);
      check({24'h0, channel_b_gain_adjust}, 32'h34);
      check({28'h0, reference_voltage_adjust}, 32'h9);
      check({24'h0, channel_a_termination_adjust}, 32'h56);
      check({24'h0, channel_b_termination_adjust}, 32'h78);
      apb(1'b0, `CVT_IDX_ACCESS_EN, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `CVT_IDX_VEC_PORT, 32'h77);
      apb(1'b0, `CVT_IDX_VEC_PORT, 32'h0);
      check(rd, 32'h0);
      foreach (rows[k])
      begin
         apb(1'b1, rows[k].idx, rows[k].wd);
         apb(1'b0, rows[k].idx, 32'h0);
         check(rd, rows[k].ex);
         check({31'h0, er}, {31'h0, rows[k].err});
      end
      // restore a full vector, then save it back
      set_en(32'h1);
      for (int i = 0; i < `CVT_VEC_LEN; i++)
         apb(1'b1, `CVT_IDX_VEC_PORT, pat(i));
      for (int n = 0; n < 100 && cal_vector_valid !== 1'b1; n++)
         @(posedge pclk);
      check({31'h0, cal_vector_valid}, 32'h1);
      status_is(32'h6, 32'h2);
      foreach (rows[k])
         if (k < 4)
         begin
            engine_index <= 10'(k * 224);
            repeat (2) @(posedge pclk);
            check({24'h0, engine_byte}, pat(k * 224));
         end
      engine_index <= 10'd700;
      repeat (3) @(posedge pclk);
      check({24'h0, engine_byte}, pat(672));
      set_en(32'h0);
      set_en(32'h1);
      for (int i = 0; i < `CVT_VEC_LEN; i++)
      begin
         apb(1'b0, `CVT_IDX_VEC_PORT, 32'h0);
         check(rd, pat(i));
      end
      apb(1'b0, `CVT_IDX_VEC_PORT, 32'h0);
      check(rd, 32'h0);
      // short restore abandoned midway
      set_en(32'h0);
      set_en(32'h1);
      for (int i = 0; i < 5; i++)
         apb(1'b1, `CVT_IDX_VEC_PORT, pat(i));
      set_en(32'h0);
      repeat (4) @(posedge pclk);
      check({31'h0, cal_vector_valid}, 32'h0);
      status_is(32'h6, 32'h4);
      // access while calibration runs
      set_en(32'h1);
      status_is(32'h4, 32'h0);
      calibration_halted_flag <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, `CVT_IDX_VEC_PORT, 32'h0);
      check(rd, 32'h0);
      status_is(32'h7, 32'h4);
      // mid-run reset with new fuse values
      fuse <= 36'h9_87c6_5432;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check({24'h0, channel_a_gain_adjust}, 32'h0);
      check({28'h0, reference_voltage_adjust}, 32'h0);
      repeat (2) @(posedge pclk);
      check({24'h0, channel_a_gain_adjust}, 32'h98);
      check({24'h0, channel_b_gain_adjust}, 32'h7c);
      check({28'h0, reference_voltage_adjust}, 32'h6);
      check({24'h0, channel_a_termination_adjust}, 32'h54);
      check({24'h0, channel_b_termination_adjust}, 32'h32);
      check({31'h0, cal_vector_valid}, 32'h0);
      apb(1'b0, `CVT_IDX_ACCESS_EN, 32'h0);
      check(rd, 32'h0);
      end_sim();
   end
endmodule : tb

bind calibration_vector_and_trim_regs cal_trim_chk u_chk
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .calibration_halted_flag, .engine_index,
   .engine_byte, .cal_vector_valid, .channel_a_gain_adjust,
   .channel_b_gain_adjust, .reference_voltage_adjust,
   .channel_a_termination_adjust, .channel_b_termination_adjust
);
